// File: inc/ccfg_pkg.sv
// package of constants for the core cache configuration register
package ccfg_pkg;
	// register width
	localparam int unsigned DATA_W = 32;
	// field positions, counted from the lsb (big-endian bit n sits at 31-n)
	localparam int unsigned POS_WLINE = 25; // load word as line, big-endian bit 6
	localparam int unsigned POS_LNA  = 24;  // load no allocate, bit 7
	localparam int unsigned POS_SNA  = 23;  // store no allocate, bit 8
	localparam int unsigned POS_DPH  = 22;  // data bus priority hi, bit 9
	localparam int unsigned POS_FPR  = 20;  // fetch bus priority lsb, bits 10:11
	localparam int unsigned POS_AUX  = 17;  // aux exception enable, bit 14
	localparam int unsigned POS_LDV  = 16;  // load debug visible, bit 15
	localparam int unsigned POS_PFCA = 11;  // prefetch cachable, bit 20
	localparam int unsigned POS_PFN  = 10;  // prefetch noncachable, bit 21
	localparam int unsigned POS_NCSZ = 9;   // noncachable request size, bit 22
	localparam int unsigned POS_FNA  = 8;   // fetch no allocate, bit 23
	localparam int unsigned POS_DIS  = 4;   // debug info select, bit 27
	localparam int unsigned POS_DWS  = 0;   // debug way select, bit 31
	// writable bits; every reserved position is zero here
	localparam logic [31:0] WR_MASK  = 32'h03f3_0f11;
	// reset value of the register
	localparam logic [31:0] RST_VAL  = 32'h0000_0000;
	// line and request sizes in words
	localparam logic [3:0]  LINE_WORDS  = 4'h8;
	localparam logic [3:0]  SHORT_WORDS = 4'h4;
	localparam logic [3:0]  ONE_WORD    = 4'h1;
endpackage : ccfg_pkg

// File: rtl/ccfg_store.sv
`timescale 1ns/1ns
// register storage with write mask, reserved bits held at zero
module ccfg_store #(
	parameter int unsigned        W    = 32,
	parameter logic [W-1:0]       MASK = '1,
	parameter logic [W-1:0]       RST  = '0
) (
	input  wire logic             clk_sys_i,
	input  wire logic             nrst_i,
	input  wire logic             we_i,
	input  wire logic [W-1:0]     wdata_i,
	output logic      [W-1:0]     rdata_o
);
	// stored word
	typedef struct packed {
		logic [W-1:0] val;
	} ccfg_store_t;

	ccfg_store_t st_q;   // registered state
	ccfg_store_t st_d;   // next state

	// next value: masked write, reserved bits forced to zero
	always_comb
	begin
		st_d = st_q;
		if (we_i)
		begin
			st_d.val = wdata_i & MASK;
		end
	end

	// state register
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
			st_q <= '{val: RST};
		else
			st_q <= st_d;
	end

	assign rdata_o = st_q.val;

	reserved_zero_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(rdata_o & ~MASK) == '0)
		else $error("reserved bit set");
endmodule // ccfg_store

// File: rtl/ccfg_core.sv
`timescale 1ns/1ns
// core cache configuration register and the controls it drives
module ccfg_core (
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	// special-purpose register move port
	input  wire logic        spr_we_i,           // write strobe, one cycle
	input  wire logic [31:0] spr_wdata_i,        // move-to data
	output logic      [31:0] spr_rdata_o,        // move-from data
	// data cache unit request qualifiers
	input  wire logic        dc_load_miss_i,     // load misses the cache
	input  wire logic        dc_load_nc_i,       // noncachable load
	input  wire logic        dc_store_miss_i,    // store misses the cache
	input  wire logic        dc_prio_lo_i,       // dynamic low priority bit
	output logic             dc_load_fill_o,     // load miss fills a line
	output logic [3:0]       dc_load_words_o,    // words moved into fill buffer
	output logic             dc_store_fill_o,    // store miss fills a line
	output logic [1:0]       dc_bus_prio_o,      // data bus request priority
	output logic             aux_exc_en_o,       // auxiliary exception gate
	output logic             mem_load_visible_o, // load data shown on memory port
	// instruction cache unit controls
	input  wire logic        ic_miss_i,          // fetch misses the cache
	input  wire logic        ic_region_nc_i,     // fetch region noncachable
	output logic             ic_fill_o,          // fetch miss fills a line
	output logic             ic_prefetch_en_o,   // prefetch allowed for region
	output logic [3:0]       ic_nc_words_o,      // noncachable request size
	output logic [1:0]       ic_bus_prio_o,      // instruction bus priority
	// cache debug read
	input  wire logic [2:0]  dbg_word_i,         // address bits 27:29
	input  wire logic [31:0] dbg_a_data_i,       // way a word at dbg_word_i
	input  wire logic [31:0] dbg_b_data_i,       // way b word at dbg_word_i
	input  wire logic [31:0] dbg_a_tag_i,        // way a tag word
	input  wire logic [31:0] dbg_b_tag_i,        // way b tag word
	output logic             dbg_tag_sel_o,      // 1 tag, 0 data
	output logic             dbg_way_b_o,        // 1 way b, 0 way a
	output logic [2:0]       dbg_word_o,         // word index sent to the arrays
	output logic [31:0]      dbg_rdata_o         // registered debug result
);
	// debug result is the only local state
	typedef struct packed {
		logic [31:0] dbg;
	} ccfg_core_t;

	ccfg_core_t  st_q;   // registered state
	ccfg_core_t  st_d;   // next state
	logic [31:0] cfg;    // register contents

	// a miss fills a line unless its no-allocate bit is set
	function automatic logic miss_fills(
		input logic miss,
		input logic no_alloc
	);
		return miss && !no_alloc;
	endfunction

	// register storage, written directly at any time
	// no write sequencing
	ccfg_store #(
		.W    (ccfg_pkg::DATA_W),
		.MASK (ccfg_pkg::WR_MASK),
		.RST  (ccfg_pkg::RST_VAL)
	) ccfg_store_i (
		.clk_sys_i (clk_sys_i),
		.nrst_i    (nrst_i),
		.we_i      (spr_we_i),
		.wdata_i   (spr_wdata_i),
		.rdata_o   (cfg)
	);

	assign spr_rdata_o = cfg;

	// data side decode
	always_comb
	begin
		if (cfg[ccfg_pkg::POS_WLINE] && (dc_load_miss_i || dc_load_nc_i))
			dc_load_words_o = ccfg_pkg::LINE_WORDS;
		else
			dc_load_words_o = ccfg_pkg::ONE_WORD;
		dc_load_fill_o = miss_fills(dc_load_miss_i, cfg[ccfg_pkg::POS_LNA]);
		dc_store_fill_o = miss_fills(dc_store_miss_i, cfg[ccfg_pkg::POS_SNA]);
		dc_bus_prio_o = {cfg[ccfg_pkg::POS_DPH], dc_prio_lo_i};
		aux_exc_en_o = cfg[ccfg_pkg::POS_AUX];
		mem_load_visible_o = cfg[ccfg_pkg::POS_LDV];
	end

	// instruction side decode
	always_comb
	begin
		ic_bus_prio_o = cfg[ccfg_pkg::POS_FPR +: 2];
		ic_prefetch_en_o = ic_region_nc_i ? cfg[ccfg_pkg::POS_PFN] : cfg[ccfg_pkg::POS_PFCA];
		ic_nc_words_o = cfg[ccfg_pkg::POS_NCSZ] ? ccfg_pkg::LINE_WORDS : ccfg_pkg::SHORT_WORDS;
		ic_fill_o = miss_fills(ic_miss_i, cfg[ccfg_pkg::POS_FNA]);
	end

	// debug selects
	// info and way
	assign dbg_tag_sel_o = cfg[ccfg_pkg::POS_DIS];
	assign dbg_way_b_o   = cfg[ccfg_pkg::POS_DWS];
	assign dbg_word_o    = dbg_word_i;

	// debug result mux, registered
	always_comb
	begin
		st_d = st_q;
		case ({dbg_tag_sel_o, dbg_way_b_o})
			2'h0:    st_d.dbg = dbg_a_data_i;  // data, way a
			2'h1:    st_d.dbg = dbg_b_data_i;  // data, way b
			2'h2:    st_d.dbg = dbg_a_tag_i;   // tag, way a
			default: st_d.dbg = dbg_b_tag_i;   // tag, way b
		endcase
	end

	// state register
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign dbg_rdata_o = st_q.dbg;

	// debug read steps: the selection seen at one edge picks the next result
	sequence dbg_data_a_s;
		!dbg_tag_sel_o && !dbg_way_b_o;
	endsequence
	sequence dbg_data_b_s;
		!dbg_tag_sel_o && dbg_way_b_o;
	endsequence
	sequence dbg_tag_a_s;
		dbg_tag_sel_o && !dbg_way_b_o;
	endsequence
	sequence dbg_tag_b_s;
		dbg_tag_sel_o && dbg_way_b_o;
	endsequence

	write_lands_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		spr_we_i |=> spr_rdata_o == ($past(spr_wdata_i) & ccfg_pkg::WR_MASK))
		else $error("write not stored");
	line_load_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(cfg[ccfg_pkg::POS_WLINE] && (dc_load_miss_i || dc_load_nc_i))
			|-> dc_load_words_o == ccfg_pkg::LINE_WORDS)
		else $error("word as line wrong");
	single_load_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		!cfg[ccfg_pkg::POS_WLINE] |-> dc_load_words_o == ccfg_pkg::ONE_WORD)
		else $error("requested size wrong");
	load_alloc_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		dc_load_fill_o == (dc_load_miss_i && !spr_rdata_o[ccfg_pkg::POS_LNA]))
		else $error("load fill wrong");
	store_alloc_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		dc_store_fill_o == (dc_store_miss_i && !spr_rdata_o[ccfg_pkg::POS_SNA]))
		else $error("store fill wrong");
	data_prio_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		dc_bus_prio_o[1] == spr_rdata_o[ccfg_pkg::POS_DPH] && dc_bus_prio_o[0] == dc_prio_lo_i)
		else $error("data priority wrong");
	fetch_prio_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		spr_we_i |=> ic_bus_prio_o == $past(spr_wdata_i[21:20]))
		else $error("fetch priority wrong");
	aux_exc_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		aux_exc_en_o == spr_rdata_o[ccfg_pkg::POS_AUX])
		else $error("exception gate wrong");
	load_vis_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		mem_load_visible_o == spr_rdata_o[ccfg_pkg::POS_LDV])
		else $error("load visibility wrong");
	prefetch_cach_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		!ic_region_nc_i |-> ic_prefetch_en_o == spr_rdata_o[ccfg_pkg::POS_PFCA])
		else $error("cachable prefetch wrong");
	prefetch_nc_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		ic_region_nc_i |-> ic_prefetch_en_o == spr_rdata_o[ccfg_pkg::POS_PFN])
		else $error("noncachable prefetch wrong");
	nc_size_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		ic_nc_words_o == (spr_rdata_o[ccfg_pkg::POS_NCSZ] ? 4'h8 : 4'h4))
		else $error("request size wrong");
	fetch_alloc_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		ic_fill_o == (ic_miss_i && !spr_rdata_o[ccfg_pkg::POS_FNA]))
		else $error("fetch fill wrong");
	select_map_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		dbg_tag_sel_o == spr_rdata_o[ccfg_pkg::POS_DIS]
			&& dbg_way_b_o == spr_rdata_o[ccfg_pkg::POS_DWS])
		else $error("debug select wrong");
	dbg_result_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		dbg_data_b_s |=> dbg_rdata_o == $past(dbg_b_data_i))
		else $error("debug result wrong");
	dbg_adata_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		dbg_data_a_s |=> dbg_rdata_o == $past(dbg_a_data_i))
		else $error("debug way a data wrong");
	dbg_atag_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		dbg_tag_a_s |=> dbg_rdata_o == $past(dbg_a_tag_i))
		else $error("debug way a tag wrong");
	dbg_btag_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		dbg_tag_b_s |=> dbg_rdata_o == $past(dbg_b_tag_i))
		else $error("debug way b tag wrong");
	dbg_word_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		dbg_word_o == dbg_word_i)
		else $error("debug word index wrong");
endmodule // ccfg_core

// File: dv/tb_top.sv
`timescale 1ns/1ns
// self-checking bench for the core cache configuration register
module tb_top;
	localparam logic [31:0] MASK = ccfg_pkg::WR_MASK; // writable positions
	logic        clk_sys_i, nrst_i, spr_we_i;            // clock, reset, write strobe
	logic [31:0] spr_wdata_i, spr_rdata_o, dbg_rdata_o;  // register and debug words
	logic        dc_load_miss_i, dc_load_nc_i, dc_store_miss_i, dc_prio_lo_i;
	logic        dc_load_fill_o, dc_store_fill_o, aux_exc_en_o, mem_load_visible_o;
	logic [3:0]  dc_load_words_o, ic_nc_words_o;         // word counts
	logic [1:0]  dc_bus_prio_o, ic_bus_prio_o;           // bus priorities
	logic        ic_miss_i, ic_region_nc_i, ic_fill_o, ic_prefetch_en_o;
	logic [2:0]  dbg_word_i, dbg_word_o;                 // debug word index
	logic [31:0] dbg_a_data_i, dbg_b_data_i, dbg_a_tag_i, dbg_b_tag_i;
	logic        dbg_tag_sel_o, dbg_way_b_o;             // debug selects
	logic [31:0] m, v;                                   // register model, pattern
	int          errors, total_checks, cyc;              // counters

	ccfg_core ccfg_core_i (.clk_sys_i, .nrst_i, .spr_we_i, .spr_wdata_i, .spr_rdata_o,
		.dc_load_miss_i, .dc_load_nc_i, .dc_store_miss_i, .dc_prio_lo_i, .dc_load_fill_o,
		.dc_load_words_o, .dc_store_fill_o, .dc_bus_prio_o, .aux_exc_en_o,
		.mem_load_visible_o, .ic_miss_i, .ic_region_nc_i, .ic_fill_o, .ic_prefetch_en_o,
		.ic_nc_words_o, .ic_bus_prio_o, .dbg_word_i, .dbg_a_data_i, .dbg_b_data_i,
		.dbg_a_tag_i, .dbg_b_tag_i, .dbg_tag_sel_o, .dbg_way_b_o, .dbg_word_o, .dbg_rdata_o);

	// free-running 100 MHz clock
	initial
	begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	// compare one result, count it, report a mismatch
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	// one register write, strobe held for a single edge
	task wr(input logic [31:0] d);
		spr_we_i = 1'b1;
		spr_wdata_i = d;
		m = d & MASK;
		@(posedge clk_sys_i);
		#1;
		spr_we_i = 1'b0;
	endtask

	// compare every output against the model and the current inputs
	task chk_all();
		logic [31:0] d;
		d = m[4] ? (m[0] ? dbg_b_tag_i : dbg_a_tag_i) : (m[0] ? dbg_b_data_i : dbg_a_data_i);
		chk("reg", m, spr_rdata_o);
		chk("ld_words", (m[25] && (dc_load_miss_i || dc_load_nc_i)) ? 8 : 1, dc_load_words_o);
		chk("ld_fill", dc_load_miss_i && !m[24], dc_load_fill_o);
		chk("st_fill", dc_store_miss_i && !m[23], dc_store_fill_o);
		chk("dc_prio", {m[22], dc_prio_lo_i}, dc_bus_prio_o);
		chk("ic_prio", m[21:20], ic_bus_prio_o);
		chk("aux_exc", m[17], aux_exc_en_o);
		chk("ld_vis", m[16], mem_load_visible_o);
		chk("prefetch", ic_region_nc_i ? m[10] : m[11], ic_prefetch_en_o);
		chk("nc_words", m[9] ? 8 : 4, ic_nc_words_o);
		chk("ic_fill", ic_miss_i && !m[8], ic_fill_o);
		chk("tag_sel", m[4], dbg_tag_sel_o);
		chk("way_b", m[0], dbg_way_b_o);
		chk("dbg_word", dbg_word_i, dbg_word_o);
		// debug result is registered: a new selection shows one edge later
		@(posedge clk_sys_i);
		#1;
		chk("dbg_data", d, dbg_rdata_o);
	endtask

	// print counts and verdict, stop the run
	task end_sim();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// hang guard, far above the expected run length
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			errors++;
			end_sim();
		end
	end

	// main sequence
	initial
	begin
		{nrst_i, spr_we_i, spr_wdata_i, m} = '0;
		{dc_load_miss_i, dc_load_nc_i, dc_store_miss_i, dc_prio_lo_i} = '0;
		{ic_miss_i, ic_region_nc_i, dbg_word_i} = '0;
		{dbg_a_data_i, dbg_b_data_i, dbg_a_tag_i, dbg_b_tag_i} = '0;
		repeat (8) @(posedge clk_sys_i);
		#1;
		nrst_i = 1'b1;
		chk_all();
		// walking one and walking zero over all 32 positions, inputs varied
		for (int k = 0; k < 64; k++)
		begin
			v = 32'h1 << k[4:0];
			if (k[5])
				v = ~v;
			{dc_prio_lo_i, dc_store_miss_i, dc_load_nc_i, dc_load_miss_i} = k[3:0];
			ic_miss_i = k[1];
			ic_region_nc_i = k[0] ^ k[2];
			dbg_word_i = k[2:0];
			dbg_a_data_i = 32'ha000_0000 + k;
			dbg_b_data_i = 32'hb000_0000 + k;
			dbg_a_tag_i = 32'hc000_0000 + k;
			dbg_b_tag_i = 32'hd000_0000 + k;
			wr(v);
			chk_all();
		end
		// back-to-back writes, last one wins
		spr_we_i = 1'b1;
		spr_wdata_i = 32'hffff_ffff;
		@(posedge clk_sys_i);
		#1;
		chk("b2b_reg", MASK, spr_rdata_o);
		wr(32'h0000_0011);
		chk_all();
		// reset in mid-run clears register and debug result at once
		nrst_i = 1'b0;
		#1;
		chk("rst_reg", 32'h0, spr_rdata_o);
		chk("rst_dbg", 32'h0, dbg_rdata_o);
		// release again: every output follows the cleared register
		@(posedge clk_sys_i);
		#1;
		nrst_i = 1'b1;
		m = '0;
		chk_all();
		end_sim();
	end
endmodule // tb_top
